/* File: bench/seq_error_queue_props.sv */
`timescale 1ns/1ps
module seq_error_queue_props
  import seq_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
)(
  input logic                     i_mclk,
  input logic                     i_nrst,
  input logic                     i_get_in_msg,
  input logic                     i_undef_hdr,
  input logic                     i_cmd_err,
  input logic                     i_other_err,
  input logic                     i_err_query,
  input logic                     i_queue_next_query,
  input logic                     i_clear_status,
  input logic                     i_freq_unit_wr,
  input seq_freq_unit_t           i_freq_unit,
  input logic                     i_time_unit_wr,
  input seq_time_unit_t           i_time_unit,
  input logic                     i_sweep_restart,
  input logic                     o_reply_valid,
  input logic signed [CODE_W-1:0] o_reply_code,
  input logic                     o_reply_overflow,
  input logic [3:0]               o_count,
  input logic                     o_esr_cmd_err,
  input seq_freq_unit_t           o_freq_unit,
  input seq_time_unit_t           o_time_unit,
  input logic                     o_abort,
  input logic                     o_initiate
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic qry;
  logic evt;
  assign qry = i_err_query | i_queue_next_query;
  assign evt = i_get_in_msg | i_undef_hdr | i_cmd_err | i_other_err;

  a_reply_pulse: assert property (qry |=> o_reply_valid)
    else $error("reply missing after query");
  a_count_bound: assert property (o_count <= DEPTH)
    else $error("count above depth");
  a_pop_count: assert property ((qry && !evt && !i_clear_status && o_count != 4'h0)
    |=> o_count == $past(o_count) - 4'h1) else $error("pop did not free a slot");
  a_empty_reply: assert property (qry && o_count == 4'h0
    |=> o_reply_code == CODE_NO_ERROR) else $error("empty queue reply not zero");
  a_clear_empty: assert property (i_clear_status |=> o_count == 4'h0 && !o_esr_cmd_err)
    else $error("clear left entries");
  a_ovf_mark: assert property (o_reply_valid
    |-> o_reply_overflow == (o_reply_code == CODE_OVERFLOW))
    else $error("overflow mark mismatch");
  a_flag_cause: assert property ($rose(o_esr_cmd_err)
    |-> $past(i_get_in_msg | i_undef_hdr | i_cmd_err))
    else $error("flag raised without command error");
  a_hdr_flag: assert property ((i_get_in_msg || i_undef_hdr) && !i_clear_status
    |=> o_esr_cmd_err) else $error("flag not raised");
  a_restart_seq: assert property (i_sweep_restart |=> o_abort ##1 o_initiate)
    else $error("restart sequence wrong");
  a_freq_set: assert property (i_freq_unit_wr |=> o_freq_unit == $past(i_freq_unit))
    else $error("frequency unit not taken");
  a_time_set: assert property (i_time_unit_wr |=> o_time_unit == $past(i_time_unit))
    else $error("time unit not taken");
endmodule

bind seq_error_queue seq_error_queue_props #(.DEPTH(DEPTH)) u_props (.*);

/* File: bench/seq_host.sv */
`timescale 1ns/1ps
// Remote host: drives one-cycle requests at the falling edge
module seq_host
  import seq_pkg::*;
(
  input  wire logic                 i_mclk,
  output logic [3:0]                o_ev,
  output logic signed [CODE_W-1:0]  o_code,
  output logic [CTX_W-1:0]          o_len,
  output logic [6:0]                o_cmd,
  output seq_freq_unit_t            o_fu,
  output seq_time_unit_t            o_tu
);
  initial begin
    o_ev = 4'h0;
    o_cmd = 7'h00;
    o_code = 17'h00000;
    o_len = 8'h00;
    o_fu = SEQ_FU_HZ;
    o_tu = SEQ_TU_S;
  end

  // Event bits: get, undefined header, command, other
  task automatic fire(input logic [3:0] k, input logic [16:0] c, input logic [7:0] n);
    @(negedge i_mclk);
    o_ev = k;
    o_code = c;
    o_len = n;
    @(negedge i_mclk);
    o_ev = 4'h0;
    // Stale data must not look valid once the pulse is gone
    o_code = ~c;
    o_len = ~n;
  endtask

  // Command bits: query, next, clear, esr clear, freq wr, time wr, restart
  task automatic pulse(input logic [6:0] c, input logic [1:0] f, input logic [1:0] t);
    @(negedge i_mclk);
    o_cmd = c;
    o_fu = seq_freq_unit_t'(f);
    o_tu = seq_time_unit_t'(t);
    @(negedge i_mclk);
    o_cmd = 7'h00;
    o_fu = seq_freq_unit_t'(~f);
    o_tu = seq_time_unit_t'(~t);
  endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import seq_pkg::*;
  logic                    i_mclk = 1'b0;
  logic                    i_nrst = 1'b0;
  logic [3:0]              ev;
  logic [6:0]              cm;
  logic signed [16:0]      cd;
  logic [7:0]              ln;
  logic [7:0]              rl;
  logic signed [16:0]      rc;
  logic [3:0]              cnt;
  logic                    rv;
  logic                    ro;
  logic                    fl;
  logic                    ab;
  logic                    ini;
  seq_freq_unit_t          fu;
  seq_freq_unit_t          ofu;
  seq_time_unit_t          tu;
  seq_time_unit_t          otu;
  int                      n_mismatch = 0;
  int                      cmp_count = 0;

  always #25 i_mclk = ~i_mclk;

  seq_host host (.i_mclk(i_mclk), .o_ev(ev), .o_code(cd), .o_len(ln), .o_cmd(cm),
                 .o_fu(fu), .o_tu(tu));
  seq_error_queue #(.DEPTH(QUEUE_DEPTH)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_get_in_msg(ev[3]), .i_undef_hdr(ev[2]), .i_cmd_err(ev[1]), .i_cmd_code(cd),
    .i_other_err(ev[0]), .i_other_code(cd), .i_ctx_len(ln), .i_err_query(cm[0]),
    .i_queue_next_query(cm[1]), .i_clear_status(cm[2]), .i_esr_read_clr(cm[3]),
    .i_freq_unit_wr(cm[4]), .i_freq_unit(fu), .i_time_unit_wr(cm[5]), .i_time_unit(tu),
    .i_sweep_restart(cm[6]), .o_reply_valid(rv), .o_reply_code(rc), .o_reply_len(rl),
    .o_reply_overflow(ro), .o_count(cnt), .o_esr_cmd_err(fl), .o_freq_unit(ofu),
    .o_time_unit(otu), .o_abort(ab), .o_initiate(ini));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ask(input logic nx, input logic [16:0] e);
    host.pulse(nx ? 7'h02 : 7'h01, 2'h0, 2'h0);
    chk("reply_valid", 17'h00001, 17'(rv));
    chk("reply_code", e, rc);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("count", 17'h00000, 17'(cnt));
    chk("freq", 17'(FREQ_UNIT_RST), 17'(ofu));
    chk("time", 17'(TIME_UNIT_RST), 17'(otu));
    ask(1'b0, CODE_NO_ERROR);
    ask(1'b1, CODE_NO_ERROR);
    $display("t_reset done");
  endtask

  // Eleven errors into ten slots: the last is lost, tail becomes overflow
  task automatic t_fifo();
    for (int i = 0; i < 11; i++) host.fire(4'h1, CODE_EXE_GEN - 17'(i + 1), 8'h10);
    chk("count", 17'(QUEUE_DEPTH), 17'(cnt));
    chk("flag", 17'h00000, 17'(fl));
    for (int i = 0; i < 9; i++) ask(i[0], CODE_EXE_GEN - 17'(i + 1));
    ask(1'b0, CODE_OVERFLOW);
    chk("overflow", 17'h00001, 17'(ro));
    chk("count", 17'h00000, 17'(cnt));
    ask(1'b0, CODE_NO_ERROR);
    $display("t_fifo done");
  endtask

  task automatic t_cmd();
    host.fire(4'hF, -17'sh00096, 8'h10);
    chk("count", 17'h00001, 17'(cnt));
    chk("flag", 17'h00001, 17'(fl));
    host.fire(4'h6, -17'sh00096, 8'h10);
    host.fire(4'h2, -17'sh00096, 8'hFF);
    host.fire(4'h2, -17'sh00032, 8'h10);
    host.fire(4'h1, 17'h00000, 8'h10);
    host.fire(4'h1, CODE_MAX, 8'h10);
    host.fire(4'h1, CODE_MIN, 8'h10);
    host.pulse(7'h08, 2'h0, 2'h0);
    chk("flag", 17'h00000, 17'(fl));
    ask(1'b1, CODE_GET_IN_MSG);
    ask(1'b0, CODE_UNDEF_HDR);
    ask(1'b0, -17'sh00096);
    chk("reply_len", 17'h000FF, 17'(rl));
    ask(1'b0, CODE_CMD_GEN);
    ask(1'b0, CODE_EXE_GEN);
    ask(1'b0, CODE_MAX);
    ask(1'b0, CODE_MIN);
    $display("t_cmd done");
  endtask

  task automatic t_clear();
    for (int i = 0; i < 3; i++) host.fire(4'h4, 17'h00000, 8'h10);
    host.pulse(7'h04, 2'h0, 2'h0);
    chk("count", 17'h00000, 17'(cnt));
    chk("flag", 17'h00000, 17'(fl));
    ask(1'b0, CODE_NO_ERROR);
    // Command error in the same cycle as clear-status: both entry and flag go
    fork
      host.fire(4'h2, -17'sh00096, 8'h10);
      host.pulse(7'h04, 2'h0, 2'h0);
    join
    chk("count", 17'h00000, 17'(cnt));
    chk("flag", 17'h00000, 17'(fl));
    $display("t_clear done");
  endtask

  task automatic t_units();
    for (int i = 0; i < 4; i++) begin
      host.pulse(7'h30, 2'(i), 2'(3 - i));
      chk("freq", 17'(i), 17'(ofu));
      chk("time", 17'(3 - i), 17'(otu));
    end
    host.pulse(7'h40, 2'h0, 2'h0);
    chk("abort", 17'h00001, 17'(ab));
    @(negedge i_mclk);
    chk("initiate", 17'h00001, 17'(ini));
    chk("abort", 17'h00000, 17'(ab));
    $display("t_units done");
  endtask

  initial begin
    repeat (10) @(negedge i_mclk);
    i_nrst = 1'b1;
    t_reset();
    t_fifo();
    t_cmd();
    t_clear();
    t_units();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_mismatch++;
    close_out();
  end
endmodule

/* File: core/seq_code_select.sv */
`timescale 1ns/1ps
// Picks one error code per event by fixed priority: get, undefined header, command, then other
module seq_code_select
  import seq_pkg::*;
(
  input  wire logic                     i_get_in_msg,
  input  wire logic                     i_undef_hdr,
  input  wire logic                     i_cmd_err,
  input  wire logic signed [CODE_W-1:0] i_cmd_code,
  input  wire logic                     i_other_err,
  input  wire logic signed [CODE_W-1:0] i_other_code,
  output logic                          o_valid,
  output logic signed [CODE_W-1:0]      o_code
);
  function automatic logic signed [CODE_W-1:0] clamp(input logic signed [CODE_W-1:0] c,
                                                     input logic signed [CODE_W-1:0] gen);
    logic signed [CODE_W-1:0] r;
    r = c;
    // Zero or out-of-range codes fall back to the class generic
    if (c == CODE_NO_ERROR || c < CODE_MIN || c > CODE_MAX) begin
      r = gen;
    end
    return r;
  endfunction

  always_comb begin
    o_valid = 1'b1;
    o_code  = CODE_NO_ERROR;
    if (i_get_in_msg) begin
      o_code = CODE_GET_IN_MSG;                                      // [RULE10] [RULE12]
    end else if (i_undef_hdr) begin
      o_code = CODE_UNDEF_HDR;                                       // [RULE11] [RULE12]
    end else if (i_cmd_err) begin
      o_code = seq_is_cmd_err(i_cmd_code) ? i_cmd_code : CODE_CMD_GEN; // [RULE12]
    end else if (i_other_err) begin
      // Command errors win above, so no second entry is queued
      o_code = clamp(i_other_code, CODE_EXE_GEN);                    // [RULE9] [RULE7]
    end else begin
      o_valid = 1'b0;
    end
  end
endmodule

/* File: core/seq_error_queue.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// What this block does
// (RULE1) Detected errors are held in a first-in first-out queue of ten entries.
// (RULE2) An error arriving at a full queue is dropped and the tail becomes the overflow code.
// (RULE3) Each error query returns the head entry and removes it, freeing a slot.
// (RULE4) An empty queue answers every query with code zero, no error.
// (RULE5) The queue empties at reset, on clear-status, and when its last entry is read.
// (RULE6) A reply is code, comma, then a quoted description and context of at most 255 chars.
// (RULE7) Codes are integers from -32768 to 32768; negatives are standard, positives local.
// (RULE8) Any code from -199 to -100 sets the command-error flag, bit 5 of the event status.
// (RULE9) A command-class event produces no execution, device or query error entry.
// (RULE10) A group execute trigger inside a program message queues a command error.
// (RULE11) An unrecognised header queues a command error.
// (RULE12) The most specific code is queued, the class generic only when none fits.
// (RULE13) The status-queue next query behaves exactly as the system error query.
// (RULE14) A global frequency unit of Hz, kHz, MHz or GHz, default Hz, is kept.
// (RULE15) A global time unit of s, ms, us or ns, default s, is kept and reported.
// (RULE16) Sweep restart acts as an abort followed at once by an initiate.
// ---------------------------------------------------------------
module seq_error_queue
  import seq_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
)(
  input  wire logic                     i_mclk,
  input  wire logic                     i_nrst,
  // Event inputs from the parser, one cycle each
  input  wire logic                     i_get_in_msg,
  input  wire logic                     i_undef_hdr,
  input  wire logic                     i_cmd_err,
  input  wire logic signed [CODE_W-1:0] i_cmd_code,
  input  wire logic                     i_other_err,
  input  wire logic signed [CODE_W-1:0] i_other_code,
  input  wire logic [CTX_W-1:0]         i_ctx_len,
  // Queries and commands
  input  wire logic                     i_err_query,
  input  wire logic                     i_queue_next_query,
  input  wire logic                     i_clear_status,
  input  wire logic                     i_esr_read_clr,
  input  wire logic                     i_freq_unit_wr,
  input  wire seq_freq_unit_t           i_freq_unit,
  input  wire logic                     i_time_unit_wr,
  input  wire seq_time_unit_t           i_time_unit,
  input  wire logic                     i_sweep_restart,
  // Replies
  output logic                          o_reply_valid,
  output logic signed [CODE_W-1:0]      o_reply_code,
  output logic [CTX_W-1:0]              o_reply_len,
  output logic                          o_reply_overflow,
  output logic [3:0]                    o_count,
  output logic                          o_esr_cmd_err,
  output seq_freq_unit_t                o_freq_unit,
  output seq_time_unit_t                o_time_unit,
  output logic                          o_abort,
  output logic                          o_initiate
);
  localparam int PW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // Code selection
  // ---------------------------------------------------------------
  logic                     new_valid;
  logic signed [CODE_W-1:0] new_code;

  seq_code_select u_sel (
    .i_get_in_msg (i_get_in_msg),
    .i_undef_hdr  (i_undef_hdr),
    .i_cmd_err    (i_cmd_err),
    .i_cmd_code   (i_cmd_code),
    .i_other_err  (i_other_err),
    .i_other_code (i_other_code),
    .o_valid      (new_valid),
    .o_code       (new_code)
  );

  // ---------------------------------------------------------------
  // Queue storage
  // ---------------------------------------------------------------
  logic signed [CODE_W-1:0] mem_ff   [DEPTH];
  logic [CTX_W-1:0]         len_ff   [DEPTH];
  logic signed [CODE_W-1:0] nxt_mem  [DEPTH];
  logic [CTX_W-1:0]         nxt_len  [DEPTH];
  logic [PW-1:0]            rd_ff, nxt_rd;
  logic [3:0]               cnt_ff, nxt_cnt;
  logic                     rv_ff, nxt_rv;
  logic signed [CODE_W-1:0] rc_ff, nxt_rc;
  logic [CTX_W-1:0]         rl_ff, nxt_rl;
  logic                     ro_ff, nxt_ro;
  logic                     esr_ff, nxt_esr;
  logic                     query;
  logic                     pop;
  logic [3:0]               cnt_after_pop;
  logic [PW-1:0]            head_after_pop;
  logic [PW-1:0]            wr_idx;
  logic [PW-1:0]            tail_idx;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] base, input logic [3:0] off);
    logic [PW+3:0] s;
    s = {{4{1'b0}}, base} + {{PW{1'b0}}, off};
    if (s >= (PW + 4)'(DEPTH)) begin
      s = s - (PW + 4)'(DEPTH);
    end
    return s[PW-1:0];
  endfunction

  assign query = i_err_query | i_queue_next_query;                  // [RULE13]

  always_comb begin
    pop            = query && (cnt_ff != 4'h0);                     // [RULE3]
    cnt_after_pop  = pop ? cnt_ff - 4'h1 : cnt_ff;
    head_after_pop = pop ? wrap(rd_ff, 4'h1) : rd_ff;
    wr_idx         = wrap(head_after_pop, cnt_after_pop);
    tail_idx       = wrap(head_after_pop, cnt_after_pop - 4'h1);
    nxt_rd         = head_after_pop;
    nxt_cnt        = cnt_after_pop;
    for (int i = 0; i < DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
      nxt_len[i] = len_ff[i];
    end
    if (new_valid) begin
      if (cnt_after_pop < 4'(DEPTH)) begin                         // [RULE1]
        nxt_mem[wr_idx] = new_code;
        nxt_len[wr_idx] = i_ctx_len;
        nxt_cnt         = cnt_after_pop + 4'h1;
      end else begin
        // Newest error lost; the tail entry is replaced by the overflow code
        nxt_mem[tail_idx] = CODE_OVERFLOW;                         // [RULE2]
        nxt_len[tail_idx] = 8'h00;
      end
    end
    // Clear after enqueue so a clear-status wipes same-cycle events too
    if (i_clear_status) begin
      nxt_cnt = 4'h0;                                              // [RULE5]
      nxt_rd  = '0;
    end
  end

  // ---------------------------------------------------------------
  // Reply and status flag
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rv = query;
    nxt_rc = rc_ff;
    nxt_rl = rl_ff;
    nxt_ro = ro_ff;
    if (query) begin
      if (cnt_ff != 4'h0) begin
        nxt_rc = mem_ff[rd_ff];                                    // [RULE3]
        // Description plus context capped at the reply limit
        nxt_rl = (len_ff[rd_ff] > DESC_MAX_LEN) ? DESC_MAX_LEN : len_ff[rd_ff]; // [RULE6]
        nxt_ro = (mem_ff[rd_ff] == CODE_OVERFLOW);
      end else begin
        nxt_rc = CODE_NO_ERROR;                                    // [RULE4]
        nxt_rl = 8'h00;
        nxt_ro = 1'b0;
      end
    end
    // Set wins over a same-cycle read-clear; clear-status wins over both,
    // since the entry that would explain the flag is wiped in that cycle too
    nxt_esr = (esr_ff && !i_esr_read_clr)
              || (new_valid && seq_is_cmd_err(new_code));         // [RULE8]
    if (i_clear_status) begin
      nxt_esr = 1'b0;                                              // [RULE5]
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= CODE_NO_ERROR;
        len_ff[i] <= 8'h00;
      end
      rd_ff  <= '0;
      cnt_ff <= 4'h0;                                              // [RULE5]
      rv_ff  <= 1'b0;
      rc_ff  <= CODE_NO_ERROR;
      rl_ff  <= 8'h00;
      ro_ff  <= 1'b0;
      esr_ff <= 1'b0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= nxt_mem[i];
        len_ff[i] <= nxt_len[i];
      end
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
      rv_ff  <= nxt_rv;
      rc_ff  <= nxt_rc;
      rl_ff  <= nxt_rl;
      ro_ff  <= nxt_ro;
      esr_ff <= nxt_esr;
    end
  end

  assign o_reply_valid    = rv_ff;
  assign o_reply_code     = rc_ff;
  assign o_reply_len      = rl_ff;
  assign o_reply_overflow = ro_ff;
  assign o_count          = cnt_ff;
  assign o_esr_cmd_err    = esr_ff;

  // ---------------------------------------------------------------
  // Units and sweep restart
  // ---------------------------------------------------------------
  seq_units u_units (
    .i_mclk         (i_mclk),
    .i_nrst         (i_nrst),
    .i_freq_unit_wr (i_freq_unit_wr),
    .i_freq_unit    (i_freq_unit),
    .i_time_unit_wr (i_time_unit_wr),
    .i_time_unit    (i_time_unit),
    .i_restart      (i_sweep_restart),
    .o_freq_unit    (o_freq_unit),
    .o_time_unit    (o_time_unit),
    .o_abort        (o_abort),
    .o_initiate     (o_initiate)
  );
endmodule

/* File: core/seq_units.sv */
`timescale 1ns/1ps
// Global unit settings and sweep restart sequencing
module seq_units
  import seq_pkg::*;
(
  input  wire logic           i_mclk,
  input  wire logic           i_nrst,
  input  wire logic           i_freq_unit_wr,
  input  wire seq_freq_unit_t i_freq_unit,
  input  wire logic           i_time_unit_wr,
  input  wire seq_time_unit_t i_time_unit,
  input  wire logic           i_restart,
  output seq_freq_unit_t      o_freq_unit,
  output seq_time_unit_t      o_time_unit,
  output logic                o_abort,
  output logic                o_initiate
);
  seq_freq_unit_t freq_ff, nxt_freq;
  seq_time_unit_t time_ff, nxt_time;
  logic           abort_ff, nxt_abort;
  logic           init_ff, nxt_init;

  always_comb begin
    nxt_freq  = i_freq_unit_wr ? i_freq_unit : freq_ff;  // [RULE14]
    nxt_time  = i_time_unit_wr ? i_time_unit : time_ff;  // [RULE15]
    nxt_abort = i_restart;                               // [RULE16]
    nxt_init  = abort_ff;                                // [RULE16]
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      freq_ff  <= FREQ_UNIT_RST;
      time_ff  <= TIME_UNIT_RST;
      abort_ff <= 1'b0;
      init_ff  <= 1'b0;
    end else begin
      freq_ff  <= nxt_freq;
      time_ff  <= nxt_time;
      abort_ff <= nxt_abort;
      init_ff  <= nxt_init;
    end
  end

  assign o_freq_unit = freq_ff;
  assign o_time_unit = time_ff;
  assign o_abort     = abort_ff;
  assign o_initiate  = init_ff;
endmodule

/* File: include/seq_pkg.sv */
package seq_pkg;
  // ---------------------------------------------------------------
  // Queue geometry and codes
  // ---------------------------------------------------------------
  localparam int                 QUEUE_DEPTH     = 10;
  localparam int                 CODE_W          = 17;
  localparam int                 CTX_W           = 8;
  localparam logic signed [16:0] CODE_NO_ERROR   = 17'sh00000;
  localparam logic signed [16:0] CODE_OVERFLOW   = -17'sh0015E;
  localparam logic signed [16:0] CODE_CMD_GEN    = -17'sh00064;
  localparam logic signed [16:0] CODE_CMD_LOW    = -17'sh000C7;
  localparam logic signed [16:0] CODE_CMD_HIGH   = -17'sh00064;
  localparam logic signed [16:0] CODE_EXE_GEN    = -17'sh000C8;
  localparam logic signed [16:0] CODE_GET_IN_MSG = -17'sh00069;
  localparam logic signed [16:0] CODE_UNDEF_HDR  = -17'sh00071;
  localparam logic signed [16:0] CODE_MIN        = -17'sh08000;
  localparam logic signed [16:0] CODE_MAX        = 17'sh08000;
  localparam logic [7:0]         DESC_MAX_LEN    = 8'hFF;
  localparam int                 ESR_CMD_ERR_BIT = 5;

  // ---------------------------------------------------------------
  // Unit selections
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_FU_HZ  = 2'b00,
    SEQ_FU_KHZ = 2'b01,
    SEQ_FU_MHZ = 2'b10,
    SEQ_FU_GHZ = 2'b11
  } seq_freq_unit_t;

  typedef enum logic [1:0] {
    SEQ_TU_S  = 2'b00,
    SEQ_TU_MS = 2'b01,
    SEQ_TU_US = 2'b10,
    SEQ_TU_NS = 2'b11
  } seq_time_unit_t;

  localparam seq_freq_unit_t FREQ_UNIT_RST = SEQ_FU_HZ;
  localparam seq_time_unit_t TIME_UNIT_RST = SEQ_TU_S;

  function automatic logic seq_is_cmd_err(input logic signed [16:0] code);
    return (code >= CODE_CMD_LOW) && (code <= CODE_CMD_HIGH);
  endfunction
endpackage
